// file: core/yccec_consts.vh
`ifndef YCCEC_CONSTS_VH
`define YCCEC_CONSTS_VH

// Word indices of the registers; the byte address is four times the index.
`define YCCEC_IDX_COEF 6'h00
`define YCCEC_IDX_OFT 6'h09
`define YCCEC_IDX_Y_MIN 6'h0C
`define YCCEC_IDX_Y_MAX 6'h0D
`define YCCEC_IDX_C_MIN 6'h0E
`define YCCEC_IDX_C_MAX 6'h0F
`define YCCEC_IDX_PHS 6'h10
`define YCCEC_IDX_EE_EN 6'h11
`define YCCEC_IDX_MEDIAN 6'h12
`define YCCEC_IDX_SHIFT 6'h13
`define YCCEC_IDX_DPATH 6'h14
`define YCCEC_IDX_TAP 6'h15
`define YCCEC_IDX_STATUS 6'h1E
`define YCCEC_NUM_COEF 6'h09
`define YCCEC_NUM_OFT 6'h03
`define YCCEC_NUM_TAP 6'h09

// Field positions and widths.
`define YCCEC_COEF_W 10
`define YCCEC_OFT_W 9
`define YCCEC_LIM_W 8
`define YCCEC_SHIFT_W 4
`define YCCEC_DPATH_W 3
`define YCCEC_TAP_W 10
`define YCCEC_PHS_POS_BIT 0
`define YCCEC_PHS_LPF_BIT 1
`define YCCEC_EN_BIT 0

// Reset values and the YCbCr datapath select code.
`define YCCEC_RST_COEF_RY 10'h04D
`define YCCEC_RST_COEF_GY 10'h096
`define YCCEC_RST_COEF_BY 10'h01D
`define YCCEC_RST_COEF_RCB 10'h3D5
`define YCCEC_RST_COEF_GCB 10'h3AB
`define YCCEC_RST_COEF_BCB 10'h080
`define YCCEC_RST_COEF_RCR 10'h080
`define YCCEC_RST_COEF_GCR 10'h395
`define YCCEC_RST_COEF_BCR 10'h3EB
`define YCCEC_RST_OFT_Y 9'h000
`define YCCEC_RST_OFT_C 9'h080
`define YCCEC_RST_LIM_MIN 8'h00
`define YCCEC_RST_LIM_MAX 8'hFF
`define YCCEC_RST_TAP 10'h000
`define YCCEC_DPATH_YCC 3'h3

`endif

// file: core/yccec_row.v
`timescale 1ns/1ps
`include "yccec_consts.vh"

// One output component: matrix row, rounding, offset, then saturation.
module yccec_row (
  input wire clk_i,
  input wire srst_i,
  input wire en_i,
  input wire pass_i,
  input wire [7:0] r_i,
  input wire [7:0] g_i,
  input wire [7:0] b_i,
  input wire [7:0] pass_val_i,
  input wire [9:0] kr_i,
  input wire [9:0] kg_i,
  input wire [9:0] kb_i,
  input wire [8:0] oft_i,
  input wire [7:0] lo_i,
  input wire [7:0] hi_i,
  output reg [7:0] q_o
);
  localparam signed [20:0] HALF_LSB = 21'sh0_0080;

  wire signed [18:0] prod_r;
  wire signed [18:0] prod_g;
  wire signed [18:0] prod_b;
  wire signed [20:0] acc;
  wire signed [20:0] rnd;
  wire signed [13:0] with_oft;
  wire signed [13:0] pre;
  reg [7:0] next_q;

  // Signed Q8 coefficients times unsigned pixels, summed at full width.
  assign prod_r = $signed(kr_i) * $signed({1'b0, r_i}); // RULE_01 RULE_12
  assign prod_g = $signed(kg_i) * $signed({1'b0, g_i});
  assign prod_b = $signed(kb_i) * $signed({1'b0, b_i});
  assign acc = prod_r + prod_g + prod_b;
  // Round to nearest integer, then add the signed output offset.
  assign rnd = acc + HALF_LSB; // RULE_14
  assign with_oft = $signed(rnd[20:8]) + $signed(oft_i); // RULE_03
  assign pre = pass_i ? $signed({6'h00, pass_val_i}) : with_oft;

  // Saturation happens last so the offset cannot push a sample out of range.
  always @* begin
    if (pre < $signed({6'h00, lo_i})) begin
      next_q = lo_i; // RULE_04 RULE_05
    end else if (pre > $signed({6'h00, hi_i})) begin
      next_q = hi_i;
    end else begin
      next_q = pre[7:0];
    end
  end

  // Result register, updated once per accepted pixel.
  always @(posedge clk_i) begin
    if (srst_i) begin
      q_o <= 8'h00;
    end else if (en_i) begin
      q_o <= next_q;
    end
  end
endmodule

// file: core/yccec_top.v
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "yccec_consts.vh"

// Overview of operation
// [RULE_01] Each Cb and Cr row coefficient is a 10-bit signed value with 8 fraction bits in the register's low bits.
// [RULE_02] Reset loads the chroma row defaults 939, 128, 128, 917 and 1003 for GCb, BCb, RCr, GCr and BCr.
// [RULE_03] A 9-bit signed offset is added to Y, Cb and Cr, resetting to 0 for luma and 128 for chroma.
// [RULE_04] Output luma is saturated between a programmable minimum and maximum, resetting to 0 and 255.
// [RULE_05] Output chroma is saturated between a programmable minimum and maximum, resetting to 0 and 255.
// [RULE_06] Control bit 1 enables a 1-2-1 chroma low-pass ahead of the 4:2:2 decimation, off after reset.
// [RULE_07] Control bit 0 places output chroma on a luma sample when 0 and between two luma samples when 1.
// [RULE_08] With datapath select 3 the phase bit describes the incoming chroma instead of the outgoing one.
// [RULE_09] Luma edge enhancement acts only while its enable bit is 1 and is bypassed otherwise, off after reset.
// [RULE_10] Median noise reduction inside the edge enhancer runs only while its enable bit is 1, off after reset.
// [RULE_11] The high-pass result is shifted right by a 4-bit amount 0 to 15, resetting to 0.
// [RULE_12] Luma row coefficients are 10-bit signed with 8 fraction bits and the red-to-luma one resets to 77.
// [RULE_13] Nine 10-bit signed integer taps form the 3x3 high-pass kernel of the edge enhancer.
// [RULE_14] Each component is the matrix product, rounded, plus its offset, then saturated.
// [RULE_15] Reserved register bits read as zero and ignore writes.
module yccec_top (
  input wire CLK_I,
  input wire SRST_I,
  input wire [7:0] AVS_ADDRESS_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [31:0] AVS_WRITEDATA_I,
  input wire [3:0] AVS_BYTEENABLE_I,
  output reg [31:0] AVS_READDATA_O,
  output reg AVS_WAITREQUEST_O,
  input wire PIX_VALID_I,
  input wire PIX_SOL_I,
  input wire [7:0] PIX_C0_I,
  input wire [7:0] PIX_C1_I,
  input wire [7:0] PIX_C2_I,
  output reg PAIR_VALID_O,
  output reg [7:0] Y_EVEN_O,
  output reg [7:0] Y_ODD_O,
  output reg [7:0] CB_O,
  output reg [7:0] CR_O
);
  // Register state.
  reg [9:0] coef [0:8];
  reg [8:0] oft [0:2];
  reg [7:0] luma_lower_limit;
  reg [7:0] luma_upper_limit;
  reg [7:0] chroma_lower_limit;
  reg [7:0] chroma_upper_limit;
  reg chroma_lpf_on;
  reg chroma_between_luma;
  reg edge_enhance_enable;
  reg median_noise_filter;
  reg [3:0] hpf_downshift_amount;
  reg [2:0] pipeline_datapath_select;
  reg [9:0] highpass_kernel_tap [0:8];
  reg [15:0] pair_count;

  // Bus and pixel pipeline state.
  reg [15:0] rd_val;
  reg [15:0] wr_val;
  reg valid_a;
  reg sol_a;
  reg odd_next;
  reg [7:0] comp_e [0:2];
  reg [7:0] comp_p [0:2];

  wire [5:0] idx;
  wire [5:0] coef_sel;
  wire [5:0] oft_sel;
  wire [5:0] tap_sel;
  wire in_coef;
  wire in_oft;
  wire in_tap;
  wire bus_req;
  wire ycc_in;
  wire [7:0] row_q [0:2];
  wire signed [11:0] col_sum [0:2];

  assign idx = AVS_ADDRESS_I[7:2];
  assign coef_sel = idx - `YCCEC_IDX_COEF;
  assign oft_sel = idx - `YCCEC_IDX_OFT;
  assign tap_sel = idx - `YCCEC_IDX_TAP;
  assign in_coef = (idx >= `YCCEC_IDX_COEF) && (coef_sel < `YCCEC_NUM_COEF);
  assign in_oft = (idx >= `YCCEC_IDX_OFT) && (oft_sel < `YCCEC_NUM_OFT);
  assign in_tap = (idx >= `YCCEC_IDX_TAP) && (tap_sel < `YCCEC_NUM_TAP);
  assign bus_req = AVS_READ_I | AVS_WRITE_I;
  assign ycc_in = (pipeline_datapath_select == `YCCEC_DPATH_YCC);

  // Read mux; reserved bits and unmapped words return zero.
  always @* begin
    rd_val = 16'h0000;
    if (in_coef) begin
      rd_val[9:0] = coef[coef_sel[3:0]];
    end else if (in_oft) begin
      rd_val[8:0] = oft[oft_sel[1:0]];
    end else if (in_tap) begin
      rd_val[9:0] = highpass_kernel_tap[tap_sel[3:0]];
    end else begin
      case (idx)
        `YCCEC_IDX_Y_MIN: rd_val[7:0] = luma_lower_limit;
        `YCCEC_IDX_Y_MAX: rd_val[7:0] = luma_upper_limit;
        `YCCEC_IDX_C_MIN: rd_val[7:0] = chroma_lower_limit;
        `YCCEC_IDX_C_MAX: rd_val[7:0] = chroma_upper_limit;
        `YCCEC_IDX_PHS: rd_val[1:0] = {chroma_lpf_on, chroma_between_luma};
        `YCCEC_IDX_EE_EN: rd_val[0] = edge_enhance_enable;
        `YCCEC_IDX_MEDIAN: rd_val[0] = median_noise_filter;
        `YCCEC_IDX_SHIFT: rd_val[3:0] = hpf_downshift_amount;
        `YCCEC_IDX_DPATH: rd_val[2:0] = pipeline_datapath_select;
        `YCCEC_IDX_STATUS: rd_val = pair_count;
        default: rd_val = 16'h0000;
      endcase
    end
  end

  // Byte lanes 0 and 1 merge into the current value; lanes 2 and 3 hold nothing.
  always @* begin
    wr_val = rd_val;
    if (AVS_BYTEENABLE_I[0]) begin
      wr_val[7:0] = AVS_WRITEDATA_I[7:0];
    end
    if (AVS_BYTEENABLE_I[1]) begin
      wr_val[15:8] = AVS_WRITEDATA_I[15:8];
    end
  end

  // Avalon slave with one wait state: waitrequest drops one cycle after a request appears.
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O <= 32'h0000_0000;
    end else if (bus_req && AVS_WAITREQUEST_O) begin
      AVS_WAITREQUEST_O <= 1'b0;
      AVS_READDATA_O <= {16'h0000, rd_val}; // RULE_15
    end else begin
      AVS_WAITREQUEST_O <= 1'b1;
    end
  end

  // Register writes land on the edge where waitrequest is seen low; only field bits are kept.
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      coef[0] <= `YCCEC_RST_COEF_RY; // RULE_12
      coef[1] <= `YCCEC_RST_COEF_GY;
      coef[2] <= `YCCEC_RST_COEF_BY;
      coef[3] <= `YCCEC_RST_COEF_RCB;
      coef[4] <= `YCCEC_RST_COEF_GCB; // RULE_02
      coef[5] <= `YCCEC_RST_COEF_BCB;
      coef[6] <= `YCCEC_RST_COEF_RCR;
      coef[7] <= `YCCEC_RST_COEF_GCR;
      coef[8] <= `YCCEC_RST_COEF_BCR;
      oft[0] <= `YCCEC_RST_OFT_Y; // RULE_03
      oft[1] <= `YCCEC_RST_OFT_C;
      oft[2] <= `YCCEC_RST_OFT_C;
      luma_lower_limit <= `YCCEC_RST_LIM_MIN; // RULE_04
      luma_upper_limit <= `YCCEC_RST_LIM_MAX;
      chroma_lower_limit <= `YCCEC_RST_LIM_MIN; // RULE_05
      chroma_upper_limit <= `YCCEC_RST_LIM_MAX;
      chroma_lpf_on <= 1'b0; // RULE_06
      chroma_between_luma <= 1'b0;
      edge_enhance_enable <= 1'b0; // RULE_09
      median_noise_filter <= 1'b0; // RULE_10
      hpf_downshift_amount <= 4'h0; // RULE_11
      pipeline_datapath_select <= 3'h0;
      highpass_kernel_tap[0] <= `YCCEC_RST_TAP;
      highpass_kernel_tap[1] <= `YCCEC_RST_TAP;
      highpass_kernel_tap[2] <= `YCCEC_RST_TAP;
      highpass_kernel_tap[3] <= `YCCEC_RST_TAP;
      highpass_kernel_tap[4] <= `YCCEC_RST_TAP;
      highpass_kernel_tap[5] <= `YCCEC_RST_TAP;
      highpass_kernel_tap[6] <= `YCCEC_RST_TAP;
      highpass_kernel_tap[7] <= `YCCEC_RST_TAP;
      highpass_kernel_tap[8] <= `YCCEC_RST_TAP;
    end else if (AVS_WRITE_I && !AVS_WAITREQUEST_O) begin
      if (in_coef) begin
        coef[coef_sel[3:0]] <= wr_val[9:0]; // RULE_01 RULE_15
      end else if (in_oft) begin
        oft[oft_sel[1:0]] <= wr_val[8:0];
      end else if (in_tap) begin
        highpass_kernel_tap[tap_sel[3:0]] <= wr_val[9:0]; // RULE_13
      end else begin
        case (idx)
          `YCCEC_IDX_Y_MIN: luma_lower_limit <= wr_val[7:0];
          `YCCEC_IDX_Y_MAX: luma_upper_limit <= wr_val[7:0];
          `YCCEC_IDX_C_MIN: chroma_lower_limit <= wr_val[7:0];
          `YCCEC_IDX_C_MAX: chroma_upper_limit <= wr_val[7:0];
          `YCCEC_IDX_PHS: begin
            chroma_lpf_on <= wr_val[`YCCEC_PHS_LPF_BIT];
            chroma_between_luma <= wr_val[`YCCEC_PHS_POS_BIT];
          end
          `YCCEC_IDX_EE_EN: edge_enhance_enable <= wr_val[`YCCEC_EN_BIT];
          `YCCEC_IDX_MEDIAN: median_noise_filter <= wr_val[`YCCEC_EN_BIT];
          `YCCEC_IDX_SHIFT: hpf_downshift_amount <= wr_val[3:0];
          `YCCEC_IDX_DPATH: pipeline_datapath_select <= wr_val[2:0];
          default: pipeline_datapath_select <= pipeline_datapath_select;
        endcase
      end
    end
  end

  genvar n;
  generate
    for (n = 0; n < 3; n = n + 1) begin : g_comp
      // Kernel columns folded over the rows; the current line stands in for its neighbours.
      assign col_sum[n] = $signed({{2{highpass_kernel_tap[n][9]}}, highpass_kernel_tap[n]}) +
                          $signed({{2{highpass_kernel_tap[n + 3][9]}}, highpass_kernel_tap[n + 3]}) +
                          $signed({{2{highpass_kernel_tap[n + 6][9]}}, highpass_kernel_tap[n + 6]}); // RULE_13
      // Matrix row n; in YCbCr input mode the component passes straight to saturation.
      yccec_row u_row (
        .clk_i(CLK_I),
        .srst_i(SRST_I),
        .en_i(PIX_VALID_I),
        .pass_i(ycc_in),
        .r_i(PIX_C0_I),
        .g_i(PIX_C1_I),
        .b_i(PIX_C2_I),
        .pass_val_i(n == 0 ? PIX_C0_I : (n == 1 ? PIX_C1_I : PIX_C2_I)),
        .kr_i(coef[3 * n]),
        .kg_i(coef[3 * n + 1]),
        .kb_i(coef[3 * n + 2]),
        .oft_i(oft[n]),
        .lo_i(n == 0 ? luma_lower_limit : chroma_lower_limit),
        .hi_i(n == 0 ? luma_upper_limit : chroma_upper_limit),
        .q_o(row_q[n])
      );
    end
  endgenerate

  // Chroma decimation for one pair: previous odd, even and odd samples of the line.
  function [7:0] chroma_down;
    input [7:0] cp;
    input [7:0] ce;
    input [7:0] co;
    input lpf;
    input centred;
    reg [10:0] s;
    begin
      s = 11'h000;
      if (!centred) begin
        if (lpf) begin
          s = {3'b000, cp} + {2'b00, ce, 1'b0} + {3'b000, co} + 11'h002; // RULE_06
          chroma_down = s[9:2];
        end else begin
          chroma_down = ce; // RULE_07
        end
      end else if (lpf) begin
        s = {3'b000, cp} + {2'b00, ce, 1'b0} + {3'b000, ce} + {1'b0, co, 2'b00} + 11'h004;
        chroma_down = s[10:3];
      end else begin
        s = {3'b000, ce} + {3'b000, co} + 11'h001; // RULE_07
        chroma_down = s[8:1];
      end
    end
  endfunction

  // Edge enhancer on a three-sample window: optional median, high-pass, shift, add, clamp.
  function [7:0] enhance;
    input [7:0] l;
    input [7:0] c;
    input [7:0] r;
    input signed [11:0] k0;
    input signed [11:0] k1;
    input signed [11:0] k2;
    input [3:0] sh;
    input med;
    input [7:0] lo;
    input [7:0] hi;
    reg [7:0] mn;
    reg [7:0] mx;
    reg [7:0] base;
    reg signed [23:0] hp;
    reg signed [24:0] t;
    begin
      mn = (l < c) ? l : c;
      mx = (l < c) ? c : l;
      if (!med) begin
        base = c;
      end else if (r < mn) begin
        base = mn; // RULE_10
      end else if (r > mx) begin
        base = mx;
      end else begin
        base = r;
      end
      hp = k0 * $signed({1'b0, l}) + k1 * $signed({1'b0, c}) + k2 * $signed({1'b0, r});
      hp = hp >>> sh; // RULE_11
      t = $signed({17'h0_0000, base}) + hp;
      if (t < $signed({17'h0_0000, lo})) begin
        enhance = lo; // RULE_04
      end else if (t > $signed({17'h0_0000, hi})) begin
        enhance = hi;
      end else begin
        enhance = t[7:0];
      end
    end
  endfunction

  // Row results become valid one cycle after the pixel was taken.
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      valid_a <= 1'b0;
      sol_a <= 1'b0;
    end else begin
      valid_a <= PIX_VALID_I;
      sol_a <= PIX_VALID_I & PIX_SOL_I;
    end
  end

  // Pairing: even pixels are held, each odd pixel completes a 4:2:2 pair.
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      odd_next <= 1'b0;
      comp_e[0] <= 8'h00;
      comp_e[1] <= 8'h00;
      comp_e[2] <= 8'h00;
      comp_p[0] <= 8'h00;
      comp_p[1] <= 8'h00;
      comp_p[2] <= 8'h00;
      PAIR_VALID_O <= 1'b0;
      Y_EVEN_O <= 8'h00;
      Y_ODD_O <= 8'h00;
      CB_O <= 8'h00;
      CR_O <= 8'h00;
      pair_count <= 16'h0000;
    end else begin
      PAIR_VALID_O <= 1'b0;
      if (valid_a && (sol_a || !odd_next)) begin
        odd_next <= 1'b1;
        comp_e[0] <= row_q[0];
        comp_e[1] <= row_q[1];
        comp_e[2] <= row_q[2];
        if (sol_a) begin
          comp_p[0] <= row_q[0];
          comp_p[1] <= row_q[1];
          comp_p[2] <= row_q[2];
        end
      end else if (valid_a) begin
        odd_next <= 1'b0;
        comp_p[0] <= row_q[0];
        comp_p[1] <= row_q[1];
        comp_p[2] <= row_q[2];
        PAIR_VALID_O <= 1'b1;
        pair_count <= pair_count + 16'h0001;
        if (edge_enhance_enable) begin
          Y_EVEN_O <= enhance(comp_p[0], comp_e[0], row_q[0], col_sum[0], col_sum[1], col_sum[2],
                              hpf_downshift_amount, median_noise_filter,
                              luma_lower_limit, luma_upper_limit); // RULE_09
          Y_ODD_O <= enhance(comp_e[0], row_q[0], row_q[0], col_sum[0], col_sum[1], col_sum[2],
                             hpf_downshift_amount, median_noise_filter,
                             luma_lower_limit, luma_upper_limit);
        end else begin
          Y_EVEN_O <= comp_e[0]; // RULE_09
          Y_ODD_O <= row_q[0];
        end
        // Incoming YCbCr chroma already sits where the phase bit says, so it is not moved.
        CB_O <= chroma_down(comp_p[1], comp_e[1], row_q[1], chroma_lpf_on,
                            chroma_between_luma & ~ycc_in); // RULE_08
        CR_O <= chroma_down(comp_p[2], comp_e[2], row_q[2], chroma_lpf_on,
                            chroma_between_luma & ~ycc_in); // RULE_08
      end
    end
  end
endmodule

// file: verification/yccec_props.sv
`timescale 1ns/1ps
`include "yccec_consts.vh"
// Watches bus handshake, pair timing and output ranges of the converter.
module yccec_props (
  input wire CLK_I,
  input wire SRST_I,
  input wire [7:0] AVS_ADDRESS_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [31:0] AVS_WRITEDATA_I,
  input wire [3:0] AVS_BYTEENABLE_I,
  input wire [31:0] AVS_READDATA_O,
  input wire AVS_WAITREQUEST_O,
  input wire PIX_VALID_I,
  input wire PIX_SOL_I,
  input wire PAIR_VALID_O,
  input wire [7:0] Y_EVEN_O,
  input wire [7:0] Y_ODD_O,
  input wire [7:0] CB_O,
  input wire [7:0] CR_O
);
  reg [7:0] y_lo;
  reg [7:0] y_hi;
  reg [7:0] c_lo;
  reg [7:0] c_hi;
  wire ack = !AVS_WAITREQUEST_O;
  wire rd_ack = AVS_READ_I && ack;
  // Shadow saturation limits follow each landed write to the low byte.
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      y_lo <= 8'h00;
      y_hi <= 8'hFF;
      c_lo <= 8'h00;
      c_hi <= 8'hFF;
    end else if (AVS_WRITE_I && ack && AVS_BYTEENABLE_I[0]) begin
      case (AVS_ADDRESS_I[7:2])
        `YCCEC_IDX_Y_MIN: y_lo <= AVS_WRITEDATA_I[7:0];
        `YCCEC_IDX_Y_MAX: y_hi <= AVS_WRITEDATA_I[7:0];
        `YCCEC_IDX_C_MIN: c_lo <= AVS_WRITEDATA_I[7:0];
        `YCCEC_IDX_C_MAX: c_hi <= AVS_WRITEDATA_I[7:0];
        default: ;
      endcase
    end
  end
  default clocking dc @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  wait_answer_a: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> ack)
    else $error("bus request not answered after one wait cycle");
  wait_single_a: assert property ($fell(AVS_WAITREQUEST_O) |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low for more than one cycle");
  read_upper_a: assert property (rd_ack |-> AVS_READDATA_O[31:16] == 16'h0000)
    else $error("upper read data not zero");
  coef_field_a: assert property (rd_ack && AVS_ADDRESS_I[7:2] < `YCCEC_NUM_COEF |->
    AVS_READDATA_O[15:10] == 6'h00)
    else $error("coefficient reserved bits not zero");
  map_hole_a: assert property (rd_ack && AVS_ADDRESS_I[7:2] > `YCCEC_IDX_STATUS |->
    AVS_READDATA_O == 32'h0000_0000)
    else $error("unmapped word reads nonzero");
  pair_cause_a: assert property (PAIR_VALID_O |-> $past(PIX_VALID_I, 2) && !$past(PIX_SOL_I, 2))
    else $error("pair without a preceding odd pixel");
  pair_pulse_a: assert property (PAIR_VALID_O |=> !PAIR_VALID_O)
    else $error("pair valid longer than one cycle");
  out_hold_a: assert property (!PAIR_VALID_O |-> $stable({Y_EVEN_O, Y_ODD_O, CB_O, CR_O}))
    else $error("outputs moved between pairs");
  luma_range_a: assert property (PAIR_VALID_O |->
    Y_EVEN_O >= y_lo && Y_EVEN_O <= y_hi && Y_ODD_O >= y_lo && Y_ODD_O <= y_hi)
    else $error("luma outside limits");
  chroma_range_a: assert property (PAIR_VALID_O |->
    CB_O >= c_lo && CB_O <= c_hi && CR_O >= c_lo && CR_O <= c_hi)
    else $error("chroma outside limits");
  pair_seen_c: cover property (PAIR_VALID_O);
  read_seen_c: cover property (rd_ack);
  write_seen_c: cover property (AVS_WRITE_I && ack);
endmodule
bind yccec_top yccec_props u_props (.CLK_I, .SRST_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I, .AVS_WRITEDATA_I,
  .AVS_BYTEENABLE_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O, .PIX_VALID_I, .PIX_SOL_I, .PAIR_VALID_O, .Y_EVEN_O,
  .Y_ODD_O, .CB_O, .CR_O);

// file: verification/yccec_pix_src.sv
`timescale 1ns/1ps
// Pixel source standing in for the RGB stages ahead of the converter.
module yccec_pix_src (
  input wire clk_i,
  output reg valid_o,
  output reg sol_o,
  output reg [7:0] c0_o,
  output reg [7:0] c1_o,
  output reg [7:0] c2_o
);
  // Idle with a neutral pattern on the data lines.
  initial begin
    valid_o = 1'b0;
    sol_o = 1'b0;
    {c0_o, c1_o, c2_o} = 24'h5A_5A5A;
  end
  // Presents one pixel just after a rising edge; it is taken on the next edge.
  task send(input sol, input [23:0] pix);
    @(posedge clk_i);
    valid_o <= 1'b1;
    sol_o <= sol;
    {c0_o, c1_o, c2_o} <= pix;
  endtask
  // Drops valid and inverts the data so a stale pixel never looks current.
  task idle;
    @(posedge clk_i);
    valid_o <= 1'b0;
    sol_o <= 1'b0;
    {c0_o, c1_o, c2_o} <= ~{c0_o, c1_o, c2_o};
  endtask
endmodule

// file: verification/testbench.sv
`timescale 1ns/1ps
`include "yccec_consts.vh"
// Register and pixel tests for the colour converter stage.
module testbench;
  localparam [23:0] A = 24'hFF_0000;
  localparam [23:0] B = 24'h00_00FF;
  localparam [23:0] W = 24'hFF_FFFF;
  localparam [23:0] P = 24'h32_64C8;
  localparam [23:0] Q = 24'h3C_1E28;
  localparam [335:0] RST = {16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h00FF, 16'h0000, 16'h00FF,
    16'h0000, 16'h0080, 16'h0080, 16'h0000, 16'h03EB, 16'h0395, 16'h0080, 16'h0080, 16'h03AB, 16'h03D5,
    16'h001D, 16'h0096, 16'h004D};
  reg clk = 1'b0;
  reg srst = 1'b1;
  reg [7:0] addr = 8'h00;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wdata = 32'h0000_0000;
  reg [31:0] q;
  wire [31:0] rdata;
  wire wait_req;
  wire pv;
  wire sol;
  wire [7:0] c0;
  wire [7:0] c1;
  wire [7:0] c2;
  wire pair;
  wire [7:0] ye;
  wire [7:0] yo;
  wire [7:0] cb;
  wire [7:0] cr;
  integer n_fail = 0;
  integer n_compared = 0;
  integer cyc = 0;
  integer i;
  integer m;
  yccec_top dut (.CLK_I(clk), .SRST_I(srst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_req),
    .PIX_VALID_I(pv), .PIX_SOL_I(sol), .PIX_C0_I(c0), .PIX_C1_I(c1), .PIX_C2_I(c2), .PAIR_VALID_O(pair),
    .Y_EVEN_O(ye), .Y_ODD_O(yo), .CB_O(cb), .CR_O(cr));
  yccec_pix_src src (.clk_i(clk), .valid_o(pv), .sol_o(sol), .c0_o(c0), .c1_o(c1), .c2_o(c2));
  // 250 MHz clock and a cycle ceiling that cuts a hang short.
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail = n_fail + 1;
      test_done;
    end
  end
  function automatic [15:0] rst_of(input integer k);
    rst_of = k <= 20 ? RST[k * 16 +: 16] : 16'h0000;
  endfunction
  function automatic [15:0] mask_of(input integer k);
    mask_of = k < 9 || k > 20 ? 16'h03FF : k < 12 ? 16'h01FF : k < 16 ? 16'h00FF : k == 16 ? 16'h0003 :
      k == 19 ? 16'h000F : k == 20 ? 16'h0007 : 16'h0001;
  endfunction
  // Reference conversion of one component with the reset matrix rows.
  function automatic [7:0] conv(input integer c, input [23:0] p, input integer o, input integer lo,
    input integer hi);
    integer s;
    integer r;
    integer g;
    integer b;
    r = p[23:16];
    g = p[15:8];
    b = p[7:0];
    case (c)
      0: s = 77 * r + 150 * g + 29 * b;
      1: s = (981 - 1024) * r + (939 - 1024) * g + 128 * b;
      default: s = 128 * r + (917 - 1024) * g + (1003 - 1024) * b;
    endcase
    s = ((s + 128) >>> 8) + o;
    s = s < lo ? lo : s > hi ? hi : s;
    conv = s[7:0];
  endfunction
  // Chroma of a line-start pair: bit 0 centres, bit 1 adds the 1-2-1 low-pass.
  function automatic [7:0] cmix(input integer md, input integer ce, input integer co);
    integer s;
    case (md)
      0: s = ce;
      1: s = (ce + co + 1) >> 1;
      2: s = (3 * ce + co + 2) >> 2;
      default: s = (4 * ce + 4 * co + 4) >> 3;
    endcase
    cmix = s[7:0];
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One Avalon transfer held until waitrequest is seen low at a rising edge; only the cycle ceiling ends a hang.
  task bus(input w, input [5:0] idx, input [15:0] d);
    reg low;
    @(posedge clk);
    addr <= {idx, 2'b00};
    wr <= w;
    rd <= !w;
    wdata <= {16'h0000, d};
    low = 1'b0;
    while (!low) begin
      @(posedge clk);
      low = wait_req === 1'b0;
    end
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // Releases the pixel lines and waits a bounded time for the pair pulse.
  task get_pair;
    integer k;
    src.idle;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k = k + 1;
    end while (pair !== 1'b1 && k < 8);
    if (pair !== 1'b1) n_fail = n_fail + 1;
  endtask
  task pair2(input [23:0] a, input [23:0] b);
    src.send(1'b1, a);
    src.send(1'b0, b);
    get_pair;
  endtask
  task test_done;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence: registers, matrix and chroma modes, limits, then luma enhancer.
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    for (i = 0; i < 30; i = i + 1) begin
      bus(1'b0, i[5:0], 16'h0000);
      check(q, {16'h0000, rst_of(i)});
      bus(1'b1, i[5:0], 16'hFFFF);
      bus(1'b0, i[5:0], 16'h0000);
      check(q, {16'h0000, mask_of(i)});
      bus(1'b1, i[5:0], rst_of(i));
    end
    bus(1'b1, 6'h3F, 16'hFFFF);
    bus(1'b0, 6'h3F, 16'h0000);
    check(q, 32'h0000_0000);
    for (m = 0; m < 4; m = m + 1) begin
      bus(1'b1, `YCCEC_IDX_PHS, m[15:0]);
      pair2(A, B);
      check({ye, yo, cb, cr}, {conv(0, A, 0, 0, 255), conv(0, B, 0, 0, 255),
        cmix(m, conv(1, A, 128, 0, 255), conv(1, B, 128, 0, 255)),
        cmix(m, conv(2, A, 128, 0, 255), conv(2, B, 128, 0, 255))});
    end
    bus(1'b1, `YCCEC_IDX_PHS, 16'h0000);
    bus(1'b1, `YCCEC_IDX_OFT, 16'h0064);
    bus(1'b1, `YCCEC_IDX_OFT + 6'h01, 16'h01F0);
    bus(1'b1, `YCCEC_IDX_Y_MIN, 16'h0050);
    bus(1'b1, `YCCEC_IDX_Y_MAX, 16'h00EB);
    bus(1'b1, `YCCEC_IDX_C_MIN, 16'h0010);
    bus(1'b1, `YCCEC_IDX_C_MAX, 16'h00F0);
    pair2(A, W);
    check({16'h0000, ye, yo}, {16'h0000, conv(0, A, 100, 80, 235), conv(0, W, 100, 80, 235)});
    check({16'h0000, cb, cr}, {16'h0000, conv(1, A, -16, 16, 240), conv(2, A, 128, 16, 240)});
    // A second reset in mid-run must restore the luma upper limit.
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    bus(1'b0, `YCCEC_IDX_Y_MAX, 16'h0000);
    check(q, 32'h0000_00FF);
    bus(1'b1, `YCCEC_IDX_DPATH, 16'h0003);
    bus(1'b1, `YCCEC_IDX_PHS, 16'h0001);
    pair2(P, Q);
    check({ye, yo, cb, cr}, {P[23:16], Q[23:16], P[15:8], P[7:0]});
    // Centre tap of four over a shift of two doubles each luma sample.
    bus(1'b1, `YCCEC_IDX_TAP + 6'h04, 16'h0004);
    bus(1'b1, `YCCEC_IDX_SHIFT, 16'h0002);
    bus(1'b1, `YCCEC_IDX_EE_EN, 16'h0001);
    pair2(P, Q);
    check({16'h0000, ye, yo}, 32'h0000_6478);
    bus(1'b1, `YCCEC_IDX_SHIFT, 16'h0003);
    pair2(P, Q);
    check({16'h0000, ye, yo}, 32'h0000_4B5A);
    bus(1'b1, `YCCEC_IDX_EE_EN, 16'h0000);
    pair2(P, Q);
    check({16'h0000, ye, yo}, 32'h0000_323C);
    // With zero taps the median of each window is the whole result.
    bus(1'b1, `YCCEC_IDX_TAP + 6'h04, 16'h0000);
    bus(1'b1, `YCCEC_IDX_EE_EN, 16'h0001);
    bus(1'b1, `YCCEC_IDX_MEDIAN, 16'h0001);
    src.send(1'b1, 24'h0A_8080);
    src.send(1'b0, 24'hC8_8080);
    src.send(1'b0, 24'h14_8080);
    src.send(1'b0, 24'h1E_8080);
    get_pair;
    check({16'h0000, ye, yo}, 32'h0000_1E1E);
    // Six pairs have left the stage since the mid-run reset.
    bus(1'b0, `YCCEC_IDX_STATUS, 16'h0000);
    check(q, 32'h0000_0006);
    test_done;
  end
endmodule
